// [tsa_core.sv]
/*
  tsa_core: four-channel time slot assigner between hdlc channels and
  tdm serial streams, with its register file on a classic wishbone bus.
  assumes: tdm pins are asynchronous to core_clk and much slower
  (bit clock at most about a tenth of core_clk); hdlc side is on core_clk.

*/
`timescale 1ns/1ps
module tsa_core (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  // wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [tsa_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // tdm pins, one set per channel
  input  wire logic [3:0]                tdm_bclk,
  input  wire logic [3:0]                tdm_fsync,
  input  wire logic [3:0]                tdm_rxd,
  output logic      [3:0]                tdm_txd_o,
  output logic      [3:0]                tdm_txd_oe_n,
  // hdlc channel side
  input  wire logic [3:0]                hdlc_tx_bit,
  output logic      [3:0]                hdlc_tx_take,
  output logic      [3:0]                hdlc_rx_bit,
  output logic      [3:0]                hdlc_rx_valid,
  // channel d pin flow control available
  output logic                           chan_d_flow_ok
);

  localparam int NCH = tsa_pkg::NCH;
  localparam logic [12:0] POS_MAX = 13'h1fff;

  // =====================================================================
  // decode helpers
  function automatic logic in_window(input logic [12:0] pos, input logic [11:0] first,
                                     input logic [11:0] last);
    if (first <= last) begin
      in_window = (pos >= {1'b0, first}) && (pos <= {1'b0, last});
    end else begin
      in_window = (pos >= {1'b0, first}) || (pos <= {1'b0, last});
    end
  endfunction

  function automatic logic in_pad(input logic [12:0] pos, input logic [11:0] last,
                                  input logic [2:0] cnt);
    in_pad = (pos > {1'b0, last}) && (pos <= ({1'b0, last} + {10'h000, cnt}));
  endfunction

  // =====================================================================
  // register file
  logic [NCH-1:0] en_q;
  logic [1:0]     mode_q  [NCH];
  logic [NCH-1:0] pol_q;
  logic [NCH-1:0] lvl_q;
  logic [2:0]     pad_q   [NCH];
  logic [11:0]    start_q [NCH];
  logic [11:0]    stop_q  [NCH];
  logic [1:0]     itf_q;
  logic           xsync_q;
  logic           ack_q;
  logic [31:0]    dat_q;
  logic [31:0]    rd_d;
  logic [11:0]    idx;
  logic           req;

  assign idx = wb_adr_i[13:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_q;

  // software writes land on the ack edge; reserved bits are not stored
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q    <= '0;
      pol_q   <= '0;
      lvl_q   <= '0;
      itf_q   <= 2'h0;
      xsync_q <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        mode_q[c]  <= 2'h0;
        pad_q[c]   <= 3'h0;
        start_q[c] <= 12'h000;
        stop_q[c]  <= 12'h000;
      end
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && ack_q) begin
      for (int c = 0; c < NCH; c++) begin
        if (idx == tsa_pkg::CFG_IDX[c]) begin
          if (wb_sel_i[1]) begin
            en_q[c]   <= wb_dat_i[tsa_pkg::EN_BIT];
            mode_q[c] <= wb_dat_i[tsa_pkg::MODE_LSB +: 2];
          end
          if (wb_sel_i[0]) begin
            pol_q[c] <= wb_dat_i[tsa_pkg::POL_BIT];
            lvl_q[c] <= wb_dat_i[tsa_pkg::LVL_BIT];
            pad_q[c] <= wb_dat_i[tsa_pkg::PAD_LSB +: 3];
          end
        end
        if (idx == tsa_pkg::START_IDX[c]) begin
          if (wb_sel_i[0]) start_q[c][7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) start_q[c][11:8] <= wb_dat_i[11:8];
        end
        if (idx == tsa_pkg::STOP_IDX[c]) begin
          if (wb_sel_i[0]) stop_q[c][7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) stop_q[c][11:8] <= wb_dat_i[11:8];
        end
      end
      if (idx == tsa_pkg::IDX_SYS_CFG && wb_sel_i[0]) begin
        itf_q   <= wb_dat_i[tsa_pkg::ITF_LSB +: 2];
        xsync_q <= wb_dat_i[tsa_pkg::XSYNC_BIT];
      end
    end
  end

  // per-channel state flops, declared here so the read mux can show them
  logic [NCH-1:0] acq_q;
  logic [2:0]     settle_q [NCH];

  // read mux; unmapped and reserved bits read zero
  always_comb begin
    rd_d = 32'h0000_0000;
    for (int c = 0; c < NCH; c++) begin
      if (idx == tsa_pkg::CFG_IDX[c]) begin
        rd_d[tsa_pkg::EN_BIT]          = en_q[c];
        rd_d[tsa_pkg::MODE_LSB +: 2]   = mode_q[c];
        rd_d[tsa_pkg::POL_BIT]         = pol_q[c];
        rd_d[tsa_pkg::LVL_BIT]         = lvl_q[c];
        rd_d[tsa_pkg::PAD_LSB +: 3]    = pad_q[c];
      end
      if (idx == tsa_pkg::START_IDX[c]) rd_d[11:0] = start_q[c];
      if (idx == tsa_pkg::STOP_IDX[c])  rd_d[11:0] = stop_q[c];
      if (idx == tsa_pkg::IDX_STATUS) begin
        rd_d[c]     = acq_q[c];
        rd_d[4 + c] = (settle_q[c] != 3'h0);
      end
    end
    if (idx == tsa_pkg::IDX_SYS_CFG) begin
      rd_d[tsa_pkg::ITF_LSB +: 2] = itf_q;
      rd_d[tsa_pkg::XSYNC_BIT]    = xsync_q;
    end
  end

  // one wait state: ack one edge after the request, dropped the next
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req) dat_q <= rd_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // =====================================================================
  // pin synchronisers and bit clock edge detection
  logic [NCH-1:0] bclk_s1, bclk_s2, bclk_s3, fs_s1, fs_s2, rx_s1, rx_s2;
  logic [NCH-1:0] pin_rise, pin_fall;

  // s1 feeds only s2; edges are found between s2 and s3
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bclk_s1 <= '0;
      bclk_s2 <= '0;
      bclk_s3 <= '0;
      fs_s1   <= '0;
      fs_s2   <= '0;
      rx_s1   <= '0;
      rx_s2   <= '0;
    end else begin
      bclk_s1 <= tdm_bclk;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      fs_s1   <= tdm_fsync;
      fs_s2   <= fs_s1;
      rx_s1   <= tdm_rxd;
      rx_s2   <= rx_s1;
    end
  end

  assign pin_rise = bclk_s2 & ~bclk_s3;
  assign pin_fall = ~bclk_s2 & bclk_s3;

  // =====================================================================
  // per-channel slot engine
  logic [12:0]    cnt_q    [NCH];
  logic [1:0]     mprev_q  [NCH];
  logic [NCH-1:0] en_prev_q;
  logic [NCH-1:0] ch_drv_q, ch_txd_q, ch_pad_q, take_q, rxv_q, rxb_q;
  logic [NCH-1:0] src_a, rise, fall, fs_act, rxd, dce, legal, act, win_now;
  logic [12:0]    pos_now  [NCH];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // multiplexed modes on b to d run on channel a's pins
      assign src_a[g]   = (g != 0) && mode_q[g][1];
      assign rise[g]    = src_a[g] ? pin_rise[0] : pin_rise[g];
      assign fall[g]    = src_a[g] ? pin_fall[0] : pin_fall[g];
      assign rxd[g]     = src_a[g] ? rx_s2[0] : rx_s2[g];
      assign fs_act[g]  = (src_a[g] ? fs_s2[0] : fs_s2[g]) ^ pol_q[g];
      assign dce[g]     = (mode_q[g] == tsa_pkg::MODE_DCE);
      // reserved code on a, gci on c without codec sync, raw d under uart
      assign legal[g]   = !((g == 0) && (mode_q[g] == tsa_pkg::MODE_PMUX))
                        && !((g == 2) && (mode_q[g] == tsa_pkg::MODE_GCI) && !xsync_q)
                        && !((g == 3) && !mode_q[g][1] && (itf_q == tsa_pkg::ITF_UART));
      assign act[g]     = en_q[g] && legal[g] && acq_q[g] && (settle_q[g] == 3'h0);
      // frame sync marks bit 0; counter saturates past the field range
      assign pos_now[g] = fs_act[g] ? 13'h0000 :
                          (cnt_q[g] == POS_MAX) ? POS_MAX : cnt_q[g] + 13'h0001;
      assign win_now[g] = in_window(pos_now[g], start_q[g], stop_q[g]);

      // settling after a mode switch, counted on the new mode's clock
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          mprev_q[g]  <= 2'h0;
          settle_q[g] <= 3'h0;
        end else begin
          mprev_q[g] <= mode_q[g];
          if (mprev_q[g] != mode_q[g]) begin
            settle_q[g] <= tsa_pkg::SETTLE_CLKS;
          end else if (rise[g] && settle_q[g] != 3'h0) begin
            settle_q[g] <= settle_q[g] - 3'h1;
          end
        end
      end

      // frame reacquisition: a fresh enable waits for the next sync
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          en_prev_q[g] <= 1'b0;
          acq_q[g]     <= 1'b0;
          cnt_q[g]     <= 13'h0000;
        end else begin
          en_prev_q[g] <= en_q[g];
          if (!en_q[g] || !en_prev_q[g]) begin
            acq_q[g] <= 1'b0;
          end else if (rise[g] && fs_act[g]) begin
            acq_q[g] <= 1'b1;
          end
          if (rise[g]) cnt_q[g] <= pos_now[g];
        end
      end

      // receive: every bit in dce once settled, window bits only otherwise
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          rxv_q[g] <= 1'b0;
          rxb_q[g] <= 1'b0;
        end else begin
          rxv_q[g] <= 1'b0;
          if (rise[g] && settle_q[g] == 3'h0 && (dce[g] || (act[g] && win_now[g]))) begin
            rxv_q[g] <= 1'b1;
            rxb_q[g] <= rxd[g];
          end
        end
      end

      // transmit on the falling edge for the bit the counter holds
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          ch_drv_q[g] <= 1'b0;
          ch_txd_q[g] <= 1'b1;
          ch_pad_q[g] <= 1'b0;
          take_q[g]   <= 1'b0;
        end else begin
          take_q[g] <= 1'b0;
          if (fall[g]) begin
            ch_pad_q[g] <= 1'b0;
            if (dce[g]) begin
              // during settling the hdlc bit is ignored and idle is sent
              ch_drv_q[g] <= 1'b1;
              ch_txd_q[g] <= (settle_q[g] == 3'h0) ? hdlc_tx_bit[g] : 1'b1;
              take_q[g]   <= (settle_q[g] == 3'h0);
            end else if (act[g] && in_window(cnt_q[g], start_q[g], stop_q[g])) begin
              ch_drv_q[g] <= 1'b1;
              ch_txd_q[g] <= hdlc_tx_bit[g];
              take_q[g]   <= 1'b1;
            end else if (act[g] && in_pad(cnt_q[g], stop_q[g], pad_q[g])) begin
              ch_drv_q[g] <= 1'b1;
              ch_txd_q[g] <= lvl_q[g];
              ch_pad_q[g] <= 1'b1;
            end else begin
              ch_drv_q[g] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // =====================================================================
  // pin drivers: multiplexed channels share channel a's data pin
  logic [NCH-1:0] pin_drv, pin_val;

  // lowest channel wins a collision on the shared pin
  always_comb begin
    pin_drv = '0;
    pin_val = '1;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (ch_drv_q[c]) begin
        if (src_a[c]) begin
          pin_drv[0] = 1'b1;
          pin_val[0] = ch_txd_q[c];
        end else begin
          pin_drv[c] = 1'b1;
          pin_val[c] = ch_txd_q[c];
        end
      end
    end
  end

  // output flops; channel d loses pin flow control in raw modes under hsu or uart
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tdm_txd_o      <= '1;
      tdm_txd_oe_n   <= '1;
      chan_d_flow_ok <= 1'b1;
    end else begin
      tdm_txd_o      <= pin_val;
      tdm_txd_oe_n   <= ~pin_drv;
      chan_d_flow_ok <= !(!mode_q[3][1] && (itf_q == tsa_pkg::ITF_HSU || itf_q == tsa_pkg::ITF_UART));
    end
  end

  assign hdlc_tx_take  = take_q;
  assign hdlc_rx_bit   = rxb_q;
  assign hdlc_rx_valid = rxv_q;

  // =====================================================================
  // assertions, watched on channel a except the bus ack and channel d flow checks and the channel b mux cover (same logic for every channel)
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_bus_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single pulse");
  a_dce_bypass_rx: assert property (rise[0] && dce[0] && settle_q[0] == 3'h0 |=> hdlc_rx_valid[0])
    else $error("raw dce bit not passed to hdlc");
  a_disabled_quiet: assert property (!en_q[0] && !dce[0] && mode_q[0] == mprev_q[0] |=> !hdlc_rx_valid[0])
    else $error("disabled channel passed data");
  a_settle_load: assert property (mode_q[0] != mprev_q[0] |=> settle_q[0] == 3'h6)
    else $error("settle count not loaded with six");
  a_settle_block: assert property (settle_q[0] != 3'h0 |=> !hdlc_rx_valid[0] && !hdlc_tx_take[0])
    else $error("hdlc traffic during settling");
  a_reacquire_wait: assert property ($rose(en_q[0]) |-> !acq_q[0] [*2])
    else $error("frame acquired without waiting for sync");
  a_sync_restart: assert property (rise[0] && fs_act[0] |=> cnt_q[0] == 13'h0000)
    else $error("bit counter not restarted by sync");
  a_window_rx: assert property (rise[0] && act[0] && !dce[0] && !win_now[0] |=> !hdlc_rx_valid[0])
    else $error("bit received outside window");
  a_pad_level: assert property ($rose(ch_pad_q[0]) |-> ch_drv_q[0] && ch_txd_q[0] == $past(lvl_q[0]))
    else $error("padding bit at wrong level");
  a_flow_d_lost: assert property (itf_q == tsa_pkg::ITF_HSU && !mode_q[3][1] |=> !chan_d_flow_ok)
    else $error("channel d kept flow control");

  c_dce_bit: cover property (dce[0] && hdlc_rx_valid[0]);
  c_pad_drive: cover property (ch_pad_q[0] && ch_drv_q[0]);
  c_wrap_window: cover property (act[0] && start_q[0] > stop_q[0] && hdlc_rx_valid[0]);
  c_mux_on_a: cover property (src_a[1] && ch_drv_q[1] && !tdm_txd_oe_n[0]);

endmodule

// [tsa_pkg.sv]
/*
  tsa_pkg: shared constants of the four-channel time slot assigner.
  assumes: 32-bit classic wishbone slave, register index = byte address / 4.
*/
package tsa_pkg;

  // =====================================================================
  // geometry
  localparam int NCH   = 4;
  localparam int POS_W = 12;
  localparam int ADR_W = 14;

  // =====================================================================
  // register indices (byte address is four times the index)
  localparam logic [11:0] IDX_A_CONFIG = 12'h2c0;
  localparam logic [11:0] IDX_A_START  = 12'h2c2;
  localparam logic [11:0] IDX_A_STOP   = 12'h2c4;
  localparam logic [11:0] IDX_B_CONFIG = 12'h2c8;
  localparam logic [11:0] IDX_B_START  = 12'h2ca;
  localparam logic [11:0] IDX_B_STOP   = 12'h2cc;
  localparam logic [11:0] IDX_C_CONFIG = 12'h2d0;
  localparam logic [11:0] IDX_C_START  = 12'h2d2;
  localparam logic [11:0] IDX_C_STOP   = 12'h2d4;
  localparam logic [11:0] IDX_D_CONFIG = 12'h2d8;
  localparam logic [11:0] IDX_D_START  = 12'h2da;
  localparam logic [11:0] IDX_D_STOP   = 12'h2dc;
  localparam logic [11:0] IDX_SYS_CFG  = 12'h2e0;
  localparam logic [11:0] IDX_STATUS   = 12'h2e2;

  localparam logic [11:0] CFG_IDX   [NCH] = '{IDX_A_CONFIG, IDX_B_CONFIG, IDX_C_CONFIG, IDX_D_CONFIG};
  localparam logic [11:0] START_IDX [NCH] = '{IDX_A_START, IDX_B_START, IDX_C_START, IDX_D_START};
  localparam logic [11:0] STOP_IDX  [NCH] = '{IDX_A_STOP, IDX_B_STOP, IDX_C_STOP, IDX_D_STOP};

  // =====================================================================
  // field positions of slot_channel_config
  localparam int EN_BIT   = 15;
  localparam int MODE_LSB = 8;
  localparam int POL_BIT  = 5;
  localparam int LVL_BIT  = 4;
  localparam int PAD_LSB  = 0;
  // system_config_reg fields
  localparam int ITF_LSB   = 0;
  localparam int XSYNC_BIT = 2;

  // =====================================================================
  // codes and reset values
  localparam logic [1:0]  MODE_DCE  = 2'h0;
  localparam logic [1:0]  MODE_PCM  = 2'h1;
  localparam logic [1:0]  MODE_GCI  = 2'h2;
  localparam logic [1:0]  MODE_PMUX = 2'h3;
  localparam logic [1:0]  ITF_HSU_FULL = 2'h0;
  localparam logic [1:0]  ITF_HSU      = 2'h1;
  localparam logic [1:0]  ITF_UART     = 2'h2;
  localparam logic [15:0] RST_WORD     = 16'h0000;

  // =====================================================================
  // timing: mode settling measured in bit clocks of the new mode
  localparam logic [2:0] SETTLE_CLKS = 3'h6;

endpackage

// [tsa_tdm_far.sv]
/*
  tsa_tdm_far: behavioural tdm highway device feeding one stream.
  assumes: the device drives fsync and rxd at the bit clock fall, for sampling on the rise.
*/
`timescale 1ns/1ps
module tsa_tdm_far #(
  parameter int FRAME_BITS = 16
) (
  // frame sync polarity chosen by the bench
  input  wire logic fs_low,
  // stream pins
  output logic      bclk,
  output logic      fsync,
  output logic      rxd,
  // marks the rise of bit position 0
  output logic      frm
);
  int          pos;
  logic [15:0] lfsr;

  // ========
  // free running bit clock; a highway never pauses between frames
  initial begin
    bclk = 1'b0;
    frm  = 1'b0;
    pos  = 0;
    lfsr = 16'hace1;
    #7;
    forever begin
      fsync = (pos == 0) ^ fs_low;
      rxd   = lfsr[0];
      lfsr  = {lfsr[0] ^ lfsr[2] ^ lfsr[3] ^ lfsr[5], lfsr[15:1]};
      #100;
      bclk = 1'b1;
      frm  = (pos == 0);
      #100;
      bclk = 1'b0;
      pos  = (pos + 1) % FRAME_BITS;
    end
  end
endmodule

// [test_tdm_time_slot_assigner.sv]
/*
  test_tdm_time_slot_assigner: self-checking bench for tsa_core.
  assumes: one far-side model feeds all four streams; channel a's pin and the hdlc side of the channel under test are judged.
*/
`timescale 1ns/1ps
module test_tdm_time_slot_assigner;
  localparam int F = 16;
  logic        core_clk;
  logic        arst_n;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [13:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [3:0]  tdm_txd_o;
  logic [3:0]  tdm_txd_oe_n;
  logic [3:0]  hdlc_tx_bit;
  logic [3:0]  hdlc_tx_take;
  logic [3:0]  hdlc_rx_bit;
  logic [3:0]  hdlc_rx_valid;
  logic        chan_d_flow_ok;
  logic        fs_low;
  logic        bclk;
  logic        fsync;
  logic        rxd;
  logic        frm;
  logic        meas;
  logic [15:0] rd;
  logic [15:0] v;
  logic [15:0] mk;
  logic [11:0] ix;
  int          seed;
  int          compares;
  int          miscompares;
  int          rx_n, tk_n, drv_n, one_n, st, sp, pd, bad_n, mc;
  logic        rx_exp;

  tsa_core tsa_core_inst (
    .core_clk       (core_clk),
    .arst_n         (arst_n),
    .wb_cyc_i       (wb_cyc_i),
    .wb_stb_i       (wb_stb_i),
    .wb_we_i        (wb_we_i),
    .wb_adr_i       (wb_adr_i),
    .wb_sel_i       (wb_sel_i),
    .wb_dat_i       (wb_dat_i),
    .wb_dat_o       (wb_dat_o),
    .wb_ack_o       (wb_ack_o),
    .tdm_bclk       ({4{bclk}}),
    .tdm_fsync      ({4{fsync}}),
    .tdm_rxd        ({4{rxd}}),
    .tdm_txd_o      (tdm_txd_o),
    .tdm_txd_oe_n   (tdm_txd_oe_n),
    .hdlc_tx_bit    (hdlc_tx_bit),
    .hdlc_tx_take   (hdlc_tx_take),
    .hdlc_rx_bit    (hdlc_rx_bit),
    .hdlc_rx_valid  (hdlc_rx_valid),
    .chan_d_flow_ok (chan_d_flow_ok)
  );

  tsa_tdm_far #(.FRAME_BITS(F)) tsa_tdm_far_inst (
    .fs_low (fs_low),
    .bclk   (bclk),
    .fsync  (fsync),
    .rxd    (rxd),
    .frm    (frm)
  );

  // ========
  // clock, watchdog and frame-aligned counters
  always #12.5 core_clk = ~core_clk;
  initial begin
    #1000000;
    miscompares++;
    results();
  end
  // stream bit as it stood at the bit clock rise, for the receive data check
  always @(posedge bclk) rx_exp = rxd;
  always @(posedge core_clk) begin
    if (meas) begin
      rx_n += (hdlc_rx_valid[mc] === 1'b1);
      tk_n += (hdlc_tx_take[mc] === 1'b1);
      bad_n += (hdlc_rx_valid[mc] === 1'b1 && hdlc_rx_bit[mc] !== rx_exp);
    end
  end
  // pin sampled at the fall, before the next drive decision lands
  always @(negedge bclk) begin
    if (meas && tdm_txd_oe_n[0] === 1'b0) begin
      drv_n++;
      one_n += (tdm_txd_o[0] === 1'b1);
    end
  end

  // ========
  // checks and verdict
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp, input string what);
    compares++;
    if (got != exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ========
  // classic wishbone cycle; waits at most 20 further edges for ack, then fails
  task automatic wb(input logic we, input logic [11:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'h3;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {16'h0000, wd};
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 20) begin
      miscompares++;
      results();
    end
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  function automatic int exp_bits(input int s0, input int s1);
    int last;
    last = (s1 < F) ? s1 : F - 1;
    if (s0 <= s1) return (s0 < F) ? last - s0 + 1 : 0;
    return ((s0 < F) ? F - s0 : 0) + last + 1;
  endfunction

  // ========
  // configure the channel under test (a by default), let it acquire, then count two frames
  task automatic run_case(input logic [1:0] md, input logic en, input int s0, input int s1, input int pc,
                          input logic lv, input logic pl, input int ch = 0);
    logic [15:0] cfg;
    int ex;
    int pe;
    logic sl;
    cfg = {en, 5'h00, md, 2'h0, pl, lv, 1'b0, pc[2:0]};
    // slot modes: raw pcm, or pcm multiplexed on a for channel b; gci on c needs codec sync
    sl = en && (md == tsa_pkg::MODE_PCM || (ch == 1 && md == tsa_pkg::MODE_PMUX));
    ex = (md == tsa_pkg::MODE_DCE) ? F : sl ? exp_bits(s0, s1) : 0;
    pe = (sl && ex > 0 && s1 < F) ? pc : 0;
    mc = ch;
    fs_low = pl;
    hdlc_tx_bit <= {4{~lv}};
    wb(1'b0, tsa_pkg::CFG_IDX[ch], 16'h0000);
    wb(1'b1, tsa_pkg::CFG_IDX[ch], {1'b0, rd[14:0]});
    wb(1'b1, tsa_pkg::CFG_IDX[ch], {1'b0, cfg[14:0]});
    wb(1'b1, tsa_pkg::START_IDX[ch], {4'h0, s0[11:0]});
    wb(1'b1, tsa_pkg::STOP_IDX[ch], {4'h0, s1[11:0]});
    wb(1'b1, tsa_pkg::CFG_IDX[ch], cfg);
    wb(1'b0, tsa_pkg::CFG_IDX[ch], 16'h0000);
    chk16(rd, cfg, "config readback");
    repeat (3) @(posedge frm);
    {rx_n, tk_n, drv_n, one_n, bad_n} = '0;
    meas = 1'b1;
    repeat (2) @(posedge frm);
    meas = 1'b0;
    chkn(rx_n, 2 * ex, "received bits");
    chkn(tk_n, 2 * ex, "taken bits");
    chkn(drv_n, 2 * (ex + pe), "driven bits");
    chkn(one_n, lv ? 2 * pe : 2 * ex, "high bits");
    chkn(bad_n, 0, "received data");
    $display("test window %0d to %0d done", s0, s1);
  endtask

  // ========
  // main sequence
  initial begin
    seed = 39;
    core_clk = 1'b0;
    {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {fs_low, meas, hdlc_tx_bit, compares, miscompares} = '0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      ix = (i < 4) ? tsa_pkg::CFG_IDX[i] : (i < 8) ? tsa_pkg::START_IDX[i - 4] : tsa_pkg::STOP_IDX[i - 8];
      mk = (i < 4) ? 16'h0337 : 16'h0fff;
      wb(1'b0, ix, 16'h0000);
      chk16(rd, tsa_pkg::RST_WORD, "reset value");
      v = 16'($random(seed)) & mk;
      wb(1'b1, ix, v);
      wb(1'b0, ix, 16'h0000);
      chk16(rd, v, "readback");
    end
    for (int i = 1; i < 4; i++) wb(1'b1, tsa_pkg::CFG_IDX[i], 16'h0000);
    wb(1'b1, 12'h2c6, 16'h1234);
    wb(1'b0, 12'h2c6, 16'h0000);
    chk16(rd, 16'h0000, "unmapped read");
    wb(1'b1, tsa_pkg::IDX_SYS_CFG, {14'h0000, tsa_pkg::ITF_HSU});
    repeat (2) @(posedge core_clk);
    chk16({15'h0000, chan_d_flow_ok}, 16'h0000, "flow in raw mode");
    wb(1'b1, tsa_pkg::CFG_IDX[3], 16'h0300);
    repeat (2) @(posedge core_clk);
    chk16({15'h0000, chan_d_flow_ok}, 16'h0001, "flow in mux mode");
    wb(1'b1, tsa_pkg::CFG_IDX[3], 16'h0000);
    wb(1'b1, tsa_pkg::IDX_SYS_CFG, {14'h0000, tsa_pkg::ITF_HSU_FULL});
    repeat (2) @(posedge core_clk);
    chk16({15'h0000, chan_d_flow_ok}, 16'h0001, "flow kept");
    $display("test registers done");
    run_case(tsa_pkg::MODE_PCM, 1'b1, 0, 0, 0, 1'b0, 1'b0);
    run_case(tsa_pkg::MODE_PCM, 1'b1, 10, 3, 6, 1'b1, 1'b1);
    run_case(tsa_pkg::MODE_PCM, 1'b1, 3, 40, 2, 1'b1, 1'b0);
    run_case(tsa_pkg::MODE_PCM, 1'b1, 300, 400, 3, 1'b0, 1'b1);
    run_case(tsa_pkg::MODE_PCM, 1'b0, 2, 5, 2, 1'b1, 1'b0);
    run_case(tsa_pkg::MODE_DCE, 1'b0, 4, 6, 5, 1'b1, 1'b1);
    run_case(tsa_pkg::MODE_PMUX, 1'b1, 2, 5, 2, 1'b0, 1'b0);
    // channel a now silent on the reserved code, so channel b may use its pin
    run_case(tsa_pkg::MODE_PMUX, 1'b1, 2, 5, 2, 1'b0, 1'b0, 1);
    wb(1'b1, tsa_pkg::CFG_IDX[1], 16'h0300);
    wb(1'b1, tsa_pkg::CFG_IDX[1], 16'h0000);
    run_case(tsa_pkg::MODE_GCI, 1'b1, 2, 5, 2, 1'b1, 1'b0, 2);
    for (int k = 0; k < 4; k++) begin
      st = $unsigned($random(seed)) % F;
      sp = $unsigned($random(seed)) % F;
      pd = $unsigned($random(seed)) % 7;
      if (st > sp && sp + pd >= st) pd = st - sp - 1;
      if (st <= sp && sp + pd >= F) pd = F - 1 - sp;
      run_case(tsa_pkg::MODE_PCM, 1'b1, st, sp, pd, 1'($random(seed)), 1'($random(seed)));
    end
    results();
  end
endmodule
